// [hw/ppg_pkg.sv]
/*
 * shared constants of the paired pwm / gpio output bank:
 * register offsets, config field layout, reset values and timing counts.
 * assumes a 40 MHz system clock and a plain byte-addressed register port.
 */
package ppg_pkg;
	// bank shape
	localparam int NCH       = 16;                  // output channels
	localparam int NPAIR     = 8;                   // period generators
	localparam int CW        = 24;                  // width of all cycle counts
	localparam int AW        = 10;                  // register address width
	localparam int POS_W     = 16;                  // time-mode position fraction
	// timing
	localparam int CLK_HZ    = 40_000_000;          // system clock rate
	localparam int DEF_FREQ_HZ = 50;                // typical servo rate
	localparam int DEF_PER_CYC = CLK_HZ / DEF_FREQ_HZ;
	localparam int DEF_MIN_US  = 900;               // lowest servo position
	localparam int DEF_MAX_US  = 2100;              // highest servo position
	localparam int DEF_MIN_CYC = (CLK_HZ / 1_000_000) * DEF_MIN_US;
	localparam int DEF_MAX_CYC = (CLK_HZ / 1_000_000) * DEF_MAX_US;
	localparam logic [6:0] DUTY_FULL = 7'h64;       // 100 percent
	// register map, byte addresses
	localparam logic [AW-1:0] OFF_PER   = 10'h000;  // pair p period at +4p
	localparam logic [AW-1:0] OFF_PIN   = 10'h020;  // pin status
	localparam logic [AW-1:0] OFF_CH    = 10'h040;  // first channel block
	localparam logic [AW-1:0] OFF_CHEND = 10'h140;  // end of channel blocks
	localparam logic [3:0]    OFF_CFG   = 4'h0;     // within channel block
	localparam logic [3:0]    OFF_MIN   = 4'h4;
	localparam logic [3:0]    OFF_MAX   = 4'h8;
	localparam logic [3:0]    OFF_SET   = 4'hc;
	// config register fields
	localparam int CFG_GPIO  = 0;                   // 1: gpio, 0: pwm
	localparam int CFG_DUTY  = 1;                   // pwm: 1 duty, 0 time
	localparam int CFG_DIR   = 2;                   // gpio: 1 output
	localparam int CFG_CMD   = 4;                   // gpio command, 2 bits
	localparam int CFG_W     = 6;
	localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
	localparam logic [1:0] CMD_OFF = 2'h0;
	localparam logic [1:0] CMD_ON  = 2'h1;
	localparam logic [1:0] CMD_PHI = 2'h2;          // single high pulse
	localparam logic [1:0] CMD_PLO = 2'h3;          // single low pulse
	localparam logic [CW-1:0] SET_RST = 24'h000000;
endpackage

// [hw/ppg_chan.sv]
/*
 * one output channel: pwm (time or duty mode) or gpio with four states.
 * assumes the pair period generator in the top supplies count and start.
 */
`timescale 1ns/1ps
`default_nettype none
module ppg_chan import ppg_pkg::*; #(
	parameter logic [CW-1:0] MIN_RST = CW'(DEF_MIN_CYC),
	parameter logic [CW-1:0] MAX_RST = CW'(DEF_MAX_CYC)
) (
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	input  wire logic              i_wr_cfg,
	input  wire logic              i_wr_min,
	input  wire logic              i_wr_max,
	input  wire logic              i_wr_set,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_start,
	input  wire logic [CW-1:0]     i_cnt,
	input  wire logic [CW-1:0]     i_nper,
	output logic                   o_out,
	output logic                   o_oe,
	output logic [CFG_W-1:0]       o_cfg,
	output logic [CW-1:0]          o_min,
	output logic [CW-1:0]          o_max,
	output logic [CW-1:0]          o_set
);
	typedef struct packed {
		logic [CFG_W-1:0] cfg;   // mode, direction, command
		logic [CW-1:0]    mn;    // min width
		logic [CW-1:0]    mx;    // max width
		logic [CW-1:0]    set;   // position, duty or pulse width
		logic [CW-1:0]    wid;   // width latched for this period
		logic [CW-1:0]    pcnt;  // single pulse cycles left
		logic             pact;  // single pulse running
		logic             lvl;   // gpio level
		logic             out;
		logic             oe;
	} ppg_ch_t;

	ppg_ch_t s;                   // current state
	ppg_ch_t n;                   // next state
	logic [1:0]          cmd;     // command being written
	logic [6:0]          duty;    // clamped percent
	logic [CW+6:0]       dprod;   // period times percent
	logic [CW+POS_W-1:0] tprod;   // span times position
	logic [CW-1:0]       duty_w;
	logic [CW-1:0]       time_w;

	// width candidates for the coming period
	always_comb begin
		duty = (s.set > CW'(DUTY_FULL)) ? DUTY_FULL : s.set[6:0];
		dprod = i_nper * duty;
		duty_w = CW'(dprod / (CW+7)'(100));
		tprod = (s.mx - s.mn) * s.set[POS_W-1:0];
		if (s.mx > s.mn) begin
			time_w = s.mn + tprod[CW+POS_W-1:POS_W];
		end else begin
			time_w = s.mn;
		end
	end

	// next state
	always_comb begin
		n = s;
		cmd = i_wdata[CFG_CMD+1:CFG_CMD];
		if (i_wr_min) n.mn = i_wdata[CW-1:0];
		if (i_wr_max) n.mx = i_wdata[CW-1:0];
		if (i_wr_set) n.set = i_wdata[CW-1:0];
		// settings only bite at a period boundary
		if (i_start) begin
			n.wid = s.cfg[CFG_DUTY] ? duty_w : time_w;
		end
		// single pulse count down, then the opposite level holds
		if (s.pact) begin
			if (s.pcnt <= CW'(1)) begin
				n.pact = 1'b0;
				n.lvl = ~s.lvl;
			end else begin
				n.pcnt = s.pcnt - CW'(1);
			end
		end
		// a config write issues the gpio command
		if (i_wr_cfg) begin
			n.cfg = i_wdata[CFG_W-1:0];
			n.pact = 1'b0;
			case (cmd)
				CMD_OFF: n.lvl = 1'b0;
				CMD_ON: n.lvl = 1'b1;
				CMD_PHI: begin
					n.lvl = 1'b1;
					n.pact = 1'b1;
					n.pcnt = s.set;
				end
				default: begin
					n.lvl = 1'b0;
					n.pact = 1'b1;
					n.pcnt = s.set;
				end
			endcase
		end
		// pin drive
		if (s.cfg[CFG_GPIO]) begin
			n.oe = s.cfg[CFG_DIR];
			n.out = s.cfg[CFG_DIR] & s.lvl;
		end else begin
			n.oe = 1'b1;
			n.out = (i_cnt < s.wid);
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			s <= '{cfg: CFG_RST, mn: MIN_RST, mx: MAX_RST, set: SET_RST,
				wid: SET_RST, pcnt: SET_RST, default: 1'b0};
		end else begin
			s <= n;
		end
	end

	assign o_out = s.out;
	assign o_oe  = s.oe;
	assign o_cfg = s.cfg;
	assign o_min = s.mn;
	assign o_max = s.mx;
	assign o_set = s.set;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// gpio arming write and the level that must follow
	sequence arm_s(logic [1:0] c);
		i_wr_cfg && i_wdata[CFG_GPIO] && i_wdata[CFG_DIR] && cmd == c;
	endsequence
	sequence lead_s(logic l);
		s.pact && s.lvl == l ##1 o_out == l;
	endsequence
	steady_on_a: assert property (s.cfg[CFG_GPIO] && s.cfg[CFG_DIR] &&
		s.cfg[CFG_CMD+1:CFG_CMD] == CMD_ON |=> o_out) else $error("gpio on not high");
	steady_off_a: assert property (s.cfg[CFG_GPIO] &&
		s.cfg[CFG_CMD+1:CFG_CMD] == CMD_OFF |=> !o_out) else $error("gpio off not low");
	pulse_high_a: assert property (arm_s(CMD_PHI) |=> lead_s(1'b1))
		else $error("high pulse did not start");
	pulse_low_a: assert property (arm_s(CMD_PLO) |=> lead_s(1'b0))
		else $error("low pulse did not start");
	pulse_end_a: assert property (s.pact && s.pcnt <= CW'(1) && !i_wr_cfg
		|=> !s.pact && s.lvl != $past(s.lvl)) else $error("pulse did not end");
	wid_hold_a: assert property (!i_start |=> $stable(s.wid))
		else $error("width changed mid period");
	time_range_a: assert property (i_start && !s.cfg[CFG_DUTY] && s.mn <= s.mx
		|=> s.wid >= $past(s.mn) && s.wid <= $past(s.mx)) else $error("width out of range");
	duty_zero_a: assert property (!s.cfg[CFG_GPIO] && s.wid == '0 |=> !o_out)
		else $error("zero width pulsed");
endmodule
`default_nettype wire

// [hw/ppg_top.sv]
/*
 * paired pwm / gpio output bank: sixteen channels, eight shared period
 * generators, a plain register port and input synchronisers.
 * assumes one 40 MHz clock, synchronous active-low reset, and a master
 * that never issues read and write strobes in the same cycle.
 */
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ppg_top import ppg_pkg::*; #(
	parameter logic [CW-1:0] DEF_PER = CW'(DEF_PER_CYC), // reset period
	parameter logic [CW-1:0] DEF_MIN = CW'(DEF_MIN_CYC), // reset min width
	parameter logic [CW-1:0] DEF_MAX = CW'(DEF_MAX_CYC)  // reset max width
) (
	input  wire logic              I_CLK,
	input  wire logic              I_NRST,
	input  wire logic [AW-1:0]     I_ADDR,
	input  wire logic [31:0]       I_WDATA,
	input  wire logic              I_WR,
	input  wire logic              I_RD,
	output logic [31:0]            O_RDATA,
	input  wire logic [NCH-1:0]    I_PIN,
	output logic [NCH-1:0]         O_PIN,
	output logic [NCH-1:0]         O_PIN_OE
);
	// whole state of the top
	typedef struct packed {
		logic [NPAIR-1:0][CW-1:0] per;   // programmed periods
		logic [NPAIR-1:0][CW-1:0] cur;   // period in force
		logic [NPAIR-1:0][CW-1:0] cnt;   // position in period
		logic [NCH-1:0]           s1;    // input sync, first stage
		logic [NCH-1:0]           s2;    // input sync, second stage
		logic [NCH-1:0]           s3;    // input sync, third stage
		logic [NCH-1:0]           inv;   // filtered input level
		logic [31:0]              rdata; // read answer
	} ppg_top_t;

	ppg_top_t s;                          // current state
	ppg_top_t n;                          // next state

	// decode and per-pair helpers
	logic [AW-1:0]            rel;        // offset into channel area
	logic                     ch_hit;     // address in channel area
	logic [3:0]               ch_idx;     // addressed channel
	logic [3:0]               fld;        // field within channel block
	logic [NCH-1:0]           wr_cfg;     // per-channel write strobes
	logic [NCH-1:0]           wr_min;
	logic [NCH-1:0]           wr_max;
	logic [NCH-1:0]           wr_set;
	logic [NPAIR-1:0]         start;      // last cycle of the current period
	logic [NPAIR-1:0][CW-1:0] nper;       // period to load, never zero

	// channel read-back
	logic [NCH-1:0][CFG_W-1:0] ch_cfg;
	logic [NCH-1:0][CW-1:0]    ch_min;
	logic [NCH-1:0][CW-1:0]    ch_max;
	logic [NCH-1:0][CW-1:0]    ch_set;

	// address decode
	always_comb begin
		rel = I_ADDR - OFF_CH;
		ch_hit = (I_ADDR >= OFF_CH) && (I_ADDR < OFF_CHEND);
		ch_idx = rel[7:4];
		fld = rel[3:0];
		wr_cfg = '0;
		wr_min = '0;
		wr_max = '0;
		wr_set = '0;
		// channel field strobes
		if (I_WR && ch_hit) begin
			if (fld == OFF_CFG) begin
				wr_cfg[ch_idx] = 1'b1;
			end else if (fld == OFF_MIN) begin
				wr_min[ch_idx] = 1'b1;
			end else if (fld == OFF_MAX) begin
				wr_max[ch_idx] = 1'b1;
			end else if (fld == OFF_SET) begin
				wr_set[ch_idx] = 1'b1;
			end
		end
	end

	// period boundaries for every pair
	always_comb begin
		for (int p = 0; p < NPAIR; p++) begin
			// a zero period would never wrap; one cycle is the least
			nper[p] = (s.per[p] == '0) ? CW'(1) : s.per[p];
			start[p] = (s.cnt[p] >= s.cur[p] - CW'(1));
		end
	end

	// next state
	always_comb begin
		n = s;
		// period counters, reload at the wrap
		for (int p = 0; p < NPAIR; p++) begin
			if (start[p]) begin
				n.cnt[p] = '0;
				n.cur[p] = nper[p];
			end else begin
				n.cnt[p] = s.cnt[p] + CW'(1);
			end
		end
		// period writes, one per pair
		if (I_WR && I_ADDR < OFF_PIN && I_ADDR[1:0] == 2'h0) begin
			n.per[I_ADDR[4:2]] = I_WDATA[CW-1:0];
		end
		// pin inputs, accepted when stages two and three agree
		n.s1 = I_PIN;
		n.s2 = s.s1;
		n.s3 = s.s2;
		n.inv = (s.s2 & ~(s.s2 ^ s.s3)) | (s.inv & (s.s2 ^ s.s3));
		// read answer, zero unless a read hits a register
		n.rdata = '0;
		if (I_RD) begin
			if (I_ADDR < OFF_PIN && I_ADDR[1:0] == 2'h0) begin
				n.rdata = 32'(s.per[I_ADDR[4:2]]);
			end else if (I_ADDR == OFF_PIN) begin
				n.rdata = {O_PIN, s.inv};
			end else if (ch_hit && fld == OFF_CFG) begin
				n.rdata = 32'(ch_cfg[ch_idx]);
			end else if (ch_hit && fld == OFF_MIN) begin
				n.rdata = 32'(ch_min[ch_idx]);
			end else if (ch_hit && fld == OFF_MAX) begin
				n.rdata = 32'(ch_max[ch_idx]);
			end else if (ch_hit && fld == OFF_SET) begin
				n.rdata = 32'(ch_set[ch_idx]);
			end
		end
	end

	// state register
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			for (int p = 0; p < NPAIR; p++) begin
				s.per[p] <= DEF_PER;
				s.cur[p] <= DEF_PER;
				s.cnt[p] <= '0;
			end
			s.s1 <= '0;
			s.s2 <= '0;
			s.s3 <= '0;
			s.inv <= '0;
			s.rdata <= '0;
		end else begin
			s <= n;
		end
	end

	assign O_RDATA = s.rdata;

	// sixteen channels, two to each period generator
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		ppg_chan #(
			.MIN_RST (DEF_MIN),
			.MAX_RST (DEF_MAX)
		) u_ch (
			.i_clk    (I_CLK),
			.i_nrst   (I_NRST),
			.i_wr_cfg (wr_cfg[c]),
			.i_wr_min (wr_min[c]),
			.i_wr_max (wr_max[c]),
			.i_wr_set (wr_set[c]),
			.i_wdata  (I_WDATA),
			.i_start  (start[c/2]),
			.i_cnt    (s.cnt[c/2]),
			.i_nper   (nper[c/2]),
			.o_out    (O_PIN[c]),
			.o_oe     (O_PIN_OE[c]),
			.o_cfg    (ch_cfg[c]),
			.o_min    (ch_min[c]),
			.o_max    (ch_max[c]),
			.o_set    (ch_set[c])
		);
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);

	// per pair checks on the period generator
	for (genvar p = 0; p < NPAIR; p++) begin : g_chk
		// the counter stays inside the period in force
		cnt_range_a: assert property (s.cnt[p] < s.cur[p])
			else $error("period counter out of range");
		// a wrap loads the programmed period and restarts
		per_load_a: assert property (start[p] |=> s.cnt[p] == '0 &&
			s.cur[p] == $past(nper[p])) else $error("period not reloaded");
		// both members of the pair start together
		pair_same_a: assert property (start[p] |->
			g_ch[2*p].u_ch.i_start && g_ch[2*p+1].u_ch.i_start)
			else $error("pair members out of step");
	end

	// a read above the channel area answers zero next cycle
	rd_unmap_a: assert property (I_RD && I_ADDR >= OFF_CHEND |=> O_RDATA == '0)
		else $error("unmapped read not zero");
	// a pin input change needs two stable samples
	in_filter_a: assert property (s.inv != $past(s.inv) |->
		(($past(s.inv) ^ s.inv) & ~($past(s.s2) ^ $past(s.s3))) == ($past(s.inv) ^ s.inv))
		else $error("input changed before settling");
endmodule
`default_nettype wire

// [dv/ppg_load.sv]
/*
 * pin-side load model: servos and discrete loads on the sixteen pins.
 * assumes the bench sets the source level of every pin the bank releases.
 */
`timescale 1ns/1ps
`default_nettype none
module ppg_load (
	input  wire logic [15:0] i_pin, // bank pin levels
	input  wire logic [15:0] i_oe,  // bank drive enables
	input  wire logic [15:0] i_ext, // external source levels
	output logic      [15:0] o_pin  // level seen on each wire
);
	// driven wires read back, released ones follow the source
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			o_pin[i] = i_oe[i] ? i_pin[i] : i_ext[i];
		end
	end
endmodule
`default_nettype wire

// [dv/tb.sv]
/*
 * self-checking bench of the pwm / gpio output bank.
 * assumes shortened counts: period 100, min 10, max 40 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module tb import ppg_pkg::*; ;
	logic            I_CLK = 0;     // system clock
	logic            I_NRST = 0;    // reset, active low
	logic [AW-1:0]   I_ADDR = '0;   // register address
	logic [31:0]     I_WDATA = '0;  // write data
	logic            I_WR = 0;      // write strobe
	logic            I_RD = 0;      // read strobe
	logic [31:0]     O_RDATA;       // read data
	logic [NCH-1:0]  O_PIN;         // pin levels
	logic [NCH-1:0]  O_PIN_OE;      // pin enables
	logic [NCH-1:0]  pin_in;        // wire levels back in
	logic [NCH-1:0]  ext = '0;      // external sources
	logic [31:0]     seed = 46;     // xorshift state
	logic [31:0]     d;             // read result
	logic [31:0]     v;             // drawn value
	logic [31:0]     mn;            // drawn minimum
	int              n;             // measured count
	int              miscompares = 0;
	int              check_count = 0;
	int              cycles = 0;
	// free-running clock, 25 ns
	always #12.5 I_CLK = ~I_CLK;
	ppg_top #(.DEF_PER(24'd100), .DEF_MIN(24'd10), .DEF_MAX(24'd40)) ppg_top_inst (
		.I_CLK(I_CLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
		.I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PIN(pin_in),
		.O_PIN(O_PIN), .O_PIN_OE(O_PIN_OE));
	ppg_load ppg_load_inst (.i_pin(O_PIN), .i_oe(O_PIN_OE), .i_ext(ext), .o_pin(pin_in));
	// repeatable random source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// duty width: percent clamped to full
	function automatic logic [31:0] duty(logic [31:0] per, logic [31:0] pct);
		return per * ((pct > 100) ? 100 : pct) / 100;
	endfunction
	// time width: min plus fraction of span
	function automatic logic [31:0] tim(logic [31:0] lo, logic [31:0] hi, logic [31:0] s);
		return (hi > lo) ? lo + (hi - lo) * s / 65536 : lo;
	endfunction
	// closing report
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one comparison
	task automatic check(string s, logic [31:0] ex, logic [31:0] got);
		check_count++;
		if (got !== ex) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", s, ex, got);
		end
	endtask
	// one-cycle register write
	task automatic wr(logic [AW-1:0] a, logic [31:0] w);
		@(posedge I_CLK);
		I_WR <= 1;
		I_ADDR <= a;
		I_WDATA <= w;
		@(posedge I_CLK);
		I_WR <= 0;
	endtask
	// one-cycle read, data sampled in the following cycle
	task automatic rd(logic [AW-1:0] a, output logic [31:0] r);
		@(posedge I_CLK);
		I_RD <= 1;
		I_ADDR <= a;
		@(posedge I_CLK);
		I_RD <= 0;
		#1 r = O_RDATA;
	endtask
	// cycles a pin spends at a level
	task automatic meas(int ch, int len, logic lvl, output int c);
		c = 0;
		repeat (len) begin
			@(posedge I_CLK);
			if (O_PIN[ch] === lvl) c++;
		end
	endtask
	// hang guard
	always @(posedge I_CLK) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			finish_test();
		end
	end
	// main sequence
	initial begin
		repeat (5) @(posedge I_CLK);
		I_NRST <= 1;
		rd(10'h000, d);
		check("period0", 100, d);
		rd(10'h044, d);
		check("min0", 10, d);
		rd(10'h048, d);
		check("max0", 40, d);
		rd(10'h040, d);
		check("cfg0", 0, d);
		rd(10'h3fc, d);
		check("unmapped", 0, d);
		check("oe reset", 16'hffff, O_PIN_OE);
		check("pin reset", 0, O_PIN);
		// pair period shared by channels 0 and 1, duty corners first
		wr(10'h000, 40);
		wr(10'h050, 2);
		wr(10'h05c, 50);
		wr(10'h040, 2);
		for (int k = 0; k < 5; k++) begin
			v = (k == 0) ? 0 : (k == 1) ? 100 : (k == 2) ? 127 : rnd() % 101;
			wr(10'h04c, v);
			repeat (90) @(posedge I_CLK);
			meas(0, 40, 1, n);
			check("ch0 width", duty(40, v), n);
			meas(1, 40, 1, n);
			check("ch1 width", 20, n);
		end
		// time mode on channel 2 with drawn limits
		for (int k = 0; k < 4; k++) begin
			mn = 1 + rnd() % 20;
			v = mn + 1 + rnd() % 60;
			wr(10'h064, mn);
			wr(10'h068, v);
			d = (k == 0) ? 0 : (k == 1) ? 32'hffff : 32'(rnd() % 65536);
			wr(10'h06c, d);
			repeat (220) @(posedge I_CLK);
			meas(2, 100, 1, n);
			check("ch2 width", tim(mn, v, d), n);
		end
		// gpio steady states on channel 3
		wr(10'h070, 32'h15);
		repeat (3) @(posedge I_CLK);
		meas(3, 20, 1, n);
		check("gpio on", 20, n);
		wr(10'h070, 32'h05);
		repeat (3) @(posedge I_CLK);
		meas(3, 20, 0, n);
		check("gpio off", 20, n);
		// single pulses of both polarities
		for (int k = 0; k < 3; k++) begin
			v = 1 + rnd() % 30;
			// start each high pulse from a low pin so only the pulse counts
			wr(10'h070, 32'h05);
			repeat (4) @(posedge I_CLK);
			wr(10'h07c, v);
			wr(10'h070, 32'h25);
			meas(3, v + 20, 1, n);
			check("pulse high", v, n);
			check("after high", 0, O_PIN[3]);
			wr(10'h070, 32'h15);
			repeat (4) @(posedge I_CLK);
			wr(10'h070, 32'h35);
			meas(3, v + 20, 0, n);
			check("pulse low", v, n);
			check("after low", 1, O_PIN[3]);
		end
		// input direction on channel 5
		wr(10'h090, 32'h01);
		for (int k = 0; k < 4; k++) begin
			@(posedge I_CLK);
			ext <= (k[0]) ? ~ext : 16'(rnd());
			repeat (10) @(posedge I_CLK);
			rd(10'h020, d);
			check("input", ext[5], d[5]);
			check("in oe", 0, O_PIN_OE[5]);
		end
		// every channel switched to gpio on
		for (int c = 0; c < 16; c++) begin
			wr(10'(10'h040 + c * 16), 32'h15);
		end
		repeat (4) @(posedge I_CLK);
		check("all on", 16'hffff, O_PIN);
		check("all oe", 16'hffff, O_PIN_OE);
		finish_test();
	end
endmodule
`default_nettype wire
